// file: verilog/clock_buffer_smbus_output_control.sv
// Purpose: serial register bank and output gating for an eight-pair clock buffer
// Assumes: ref_clock_in, bus pins, power and halt pins are async to clk
// Notes: analog drive strength is not modelled; pll_enable and pll_locked stand in for the loop
`include "clkbuf_defs.svh"
module clock_buffer_smbus_output_control #(
	parameter int LOCK_CYCLES = `LOCK_CYCLES,
	parameter logic [3:0] REVISION_CODE = 4'h3, // Arbitrary value
	parameter logic [3:0] MAKER_CODE = 4'h5, // Arbitrary value
	parameter logic [7:0] PART_CODE = 8'h4C // Arbitrary value
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic ref_clock_in,
	input wire logic power_down_n,
	input wire logic output_halt_n,
	input wire logic [7:0] output_gate_pin,
	input wire logic gate_sense_invert,
	output logic [7:0] clk_out_true,
	output logic [7:0] clk_out_comp,
	output logic [7:0] true_oe_n,
	output logic [7:0] comp_oe_n,
	output logic pll_enable,
	output logic pll_locked,
	output logic loop_bandwidth_select,
	output logic input_halving_select
);
	logic rst_s1_q, rst_n;
	clkbuf_pkg::xfer_state_e state_q;
	logic [7:0] ptr_q, count_q, en_q, stoppable_q, part_q, left_q;
	logic sleep_park_q, halt_park_q, sleep_sense_q, loop_bw_q, halving_q;
	logic start_p, stop_p, rx_valid, tx_done, tx_acked, ack_req, tx_mode;
	logic [7:0] rx_byte, tx_byte;
	logic ref_s1_q, ref_q, ref_p_q, phase_q, phase_p_q, phase_rise, phase_fall;
	logic pd_synced, pd_stable, halt_stable, pd_req, stop_req;
	logic pd_park_q, pll_on_q, locked_q;
	logic [31:0] lock_cnt_q;
	logic [7:0] gate_s1_q, gate_q, stopped_q, run_q;
	logic inv_s1_q, inv_q;
	logic [7:0] true_q, comp_q, true_oe_n_q, comp_oe_n_q;

	// Register read mux; reserved and unmapped read zero
	function automatic logic [7:0] reg_read(input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			`IDX_CTRL: begin
				v[`B_SLEEP_PARK] = sleep_park_q;
				v[`B_HALT_PARK] = halt_park_q;
				v[`B_SLEEP_SENSE] = sleep_sense_q;
				v[`B_LOOP_BW] = loop_bw_q;
				v[`B_HALVING] = halving_q;
			end
			`IDX_EN: v = en_q;
			`IDX_STOPPABLE: v = stoppable_q;
			`IDX_IDENT: v = {REVISION_CODE, MAKER_CODE};
			`IDX_PART: v = part_q;
			`IDX_COUNT: v = count_q;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	smbus_bit_link u_link (
		.clk(clk),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.start_p(start_p),
		.stop_p(stop_p),
		.rx_valid(rx_valid),
		.rx_byte(rx_byte),
		.ack_req(ack_req),
		.tx_mode(tx_mode),
		.tx_byte(tx_byte),
		.tx_done(tx_done),
		.tx_acked(tx_acked)
	);

	// Foreign addresses are not acked, so the link drops out until the next start
	assign ack_req = (state_q == clkbuf_pkg::ST_ADDR) ? (rx_byte == `WR_ADDR || rx_byte == `RD_ADDR)
		: (state_q == clkbuf_pkg::ST_INDEX || state_q == clkbuf_pkg::ST_WCOUNT || state_q == clkbuf_pkg::ST_WDATA);
	assign tx_mode = (state_q == clkbuf_pkg::ST_RCOUNT || state_q == clkbuf_pkg::ST_RDATA);
	assign tx_byte = (state_q == clkbuf_pkg::ST_RCOUNT) ? count_q : reg_read(ptr_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= clkbuf_pkg::ST_IDLE;
		end else if (start_p) begin
			state_q <= clkbuf_pkg::ST_ADDR;
		end else if (stop_p) begin
			state_q <= clkbuf_pkg::ST_IDLE;
		end else if (rx_valid) begin
			unique case (state_q)
				clkbuf_pkg::ST_ADDR: begin
					if (rx_byte == `WR_ADDR) begin
						state_q <= clkbuf_pkg::ST_INDEX;
					end else if (rx_byte == `RD_ADDR) begin
						state_q <= clkbuf_pkg::ST_RCOUNT;
					end else begin
						state_q <= clkbuf_pkg::ST_IDLE;
					end
				end
				clkbuf_pkg::ST_INDEX: state_q <= clkbuf_pkg::ST_WCOUNT;
				clkbuf_pkg::ST_WCOUNT: state_q <= clkbuf_pkg::ST_WDATA;
				default: state_q <= state_q;
			endcase
		end else if (tx_done) begin
			// Host nack closes the read; it must follow with stop
			state_q <= tx_acked ? clkbuf_pkg::ST_RDATA : clkbuf_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= 8'h00;
			left_q <= 8'h00;
		end else if (rx_valid && state_q == clkbuf_pkg::ST_INDEX) begin
			ptr_q <= rx_byte;
		end else if (rx_valid && state_q == clkbuf_pkg::ST_WCOUNT) begin
			left_q <= rx_byte;
		end else if (rx_valid && state_q == clkbuf_pkg::ST_WDATA) begin
			ptr_q <= ptr_q + 8'h01;
			left_q <= left_q - 8'h01;
		end else if (tx_done && tx_acked && state_q == clkbuf_pkg::ST_RDATA) begin
			ptr_q <= ptr_q + 8'h01;
		end
	end

	// The first byte beyond the announced count is acked but not stored; left_q then wraps, so later bytes are stored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_park_q <= `RST_SLEEP_PARK;
			halt_park_q <= `RST_HALT_PARK;
			sleep_sense_q <= `RST_SLEEP_SENSE;
			loop_bw_q <= `RST_LOOP_BW;
			halving_q <= `RST_HALVING;
			en_q <= `RST_EN;
			stoppable_q <= `RST_STOPPABLE;
			part_q <= PART_CODE;
			count_q <= `RST_COUNT;
		end else if (rx_valid && state_q == clkbuf_pkg::ST_WDATA && left_q != 8'h00) begin
			unique case (ptr_q)
				`IDX_CTRL: begin
					sleep_park_q <= rx_byte[`B_SLEEP_PARK];
					halt_park_q <= rx_byte[`B_HALT_PARK];
					sleep_sense_q <= rx_byte[`B_SLEEP_SENSE];
					loop_bw_q <= rx_byte[`B_LOOP_BW];
					halving_q <= rx_byte[`B_HALVING];
				end
				`IDX_EN: en_q <= rx_byte;
				`IDX_STOPPABLE: stoppable_q <= rx_byte;
				`IDX_PART: part_q <= rx_byte;
				`IDX_COUNT: count_q <= rx_byte;
				default: count_q <= count_q;
			endcase
		end
	end

	// Reference sampled by clk; with halving_q set the phase follows it directly
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{ref_s1_q, ref_q, ref_p_q} <= 3'h0;
			phase_q <= 1'b0;
			phase_p_q <= 1'b0;
		end else begin
			{ref_s1_q, ref_q, ref_p_q} <= {ref_clock_in, ref_s1_q, ref_q};
			phase_p_q <= phase_q;
			if (halving_q) begin
				phase_q <= ref_q;
			end else if (ref_q && !ref_p_q) begin
				phase_q <= ~phase_q;
			end
		end
	end

	// Comp rises when phase falls; comp high-to-low is phase rise
	assign phase_rise = phase_q & ~phase_p_q;
	assign phase_fall = ~phase_q & phase_p_q;

	edge_debounce #(.RESET_LEVEL(1'b1)) u_pd_db (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(power_down_n),
		.sample_p(phase_fall),
		.synced(pd_synced),
		.stable(pd_stable)
	);

	edge_debounce #(.RESET_LEVEL(1'b1)) u_halt_db (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(output_halt_n),
		.sample_p(phase_fall),
		.synced(),
		.stable(halt_stable)
	);

	// Release is taken from the plain synced level: power-up needs no clock
	assign pd_req = ~pd_stable & ~pd_synced;
	assign stop_req = ~halt_stable;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_park_q <= 1'b0;
			pll_on_q <= 1'b1;
		end else begin
			if (!pd_synced && pd_req && phase_rise) begin
				pd_park_q <= 1'b1;
			end else if (pd_synced) begin
				pd_park_q <= 1'b0;
			end
			pll_on_q <= ~pd_park_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_cnt_q <= 32'h0;
			locked_q <= 1'b0;
		end else if (!pll_on_q) begin
			lock_cnt_q <= 32'h0;
			locked_q <= 1'b0;
		end else if (lock_cnt_q >= 32'(LOCK_CYCLES - 1)) begin
			locked_q <= 1'b1;
		end else begin
			lock_cnt_q <= lock_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{gate_s1_q, gate_q} <= 16'h0000;
			{inv_s1_q, inv_q} <= 2'h0;
		end else begin
			{gate_s1_q, gate_q} <= {output_gate_pin, gate_s1_q};
			{inv_s1_q, inv_q} <= {gate_sense_invert, inv_s1_q};
		end
	end

	// Stop on the edge that leaves true high; resume all at once on the same edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stopped_q <= 8'h00;
		end else if (phase_rise) begin
			stopped_q <= stop_req ? (stopped_q | stoppable_q) : 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 8'h00;
		end else begin
			run_q <= {8{locked_q & ~pd_park_q}} & en_q & (gate_q ^ {8{inv_q}}) & ~stopped_q;
		end
	end

	// Disabled pairs park as a stop would; lock wait drives true high so a tri-state park is lifted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			true_q <= 8'hFF;
			comp_q <= 8'h00;
			true_oe_n_q <= 8'h00;
			comp_oe_n_q <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (pd_park_q) begin
					true_q[i] <= 1'b1;
					comp_q[i] <= 1'b0;
					true_oe_n_q[i] <= sleep_park_q;
					comp_oe_n_q[i] <= 1'b1;
				end else if (!locked_q) begin
					true_q[i] <= 1'b1;
					comp_q[i] <= 1'b0;
					true_oe_n_q[i] <= 1'b0;
					comp_oe_n_q[i] <= 1'b0;
				end else if (run_q[i]) begin
					true_q[i] <= phase_q;
					comp_q[i] <= ~phase_q;
					true_oe_n_q[i] <= 1'b0;
					comp_oe_n_q[i] <= 1'b0;
				end else begin
					true_q[i] <= 1'b1;
					comp_q[i] <= 1'b0;
					true_oe_n_q[i] <= halt_park_q;
					comp_oe_n_q[i] <= 1'b1;
				end
			end
		end
	end

	assign clk_out_true = true_q;
	assign clk_out_comp = comp_q;
	assign true_oe_n = true_oe_n_q;
	assign comp_oe_n = comp_oe_n_q;
	assign pll_enable = pll_on_q;
	assign pll_locked = locked_q;
	assign loop_bandwidth_select = loop_bw_q;
	assign input_halving_select = halving_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_WR_ADDR: assert property (rx_valid && state_q == clkbuf_pkg::ST_ADDR && rx_byte == `WR_ADDR
		|=> state_q == clkbuf_pkg::ST_INDEX || $past(start_p) || $past(stop_p))
		else $error("write address not taken");
	AST_RD_COUNT_FIRST: assert property (rx_valid && state_q == clkbuf_pkg::ST_ADDR && rx_byte == `RD_ADDR
		|=> tx_mode && tx_byte == count_q)
		else $error("read did not start with byte count");
	AST_RD_ORDER: assert property (tx_done && tx_acked && state_q == clkbuf_pkg::ST_RDATA
		|=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("read index did not advance by one");
	AST_COUNT_WRITE: assert property (rx_valid && state_q == clkbuf_pkg::ST_WDATA && ptr_q == `IDX_COUNT && left_q != 8'h00
		|=> count_q == $past(rx_byte))
		else $error("byte count not written");
	AST_CTRL_WRITE: assert property (rx_valid && state_q == clkbuf_pkg::ST_WDATA && ptr_q == `IDX_CTRL && left_q != 8'h00
		|=> reg_read(`IDX_CTRL) == ($past(rx_byte) & 8'hE5))
		else $error("control write not masked to its fields");
	AST_GATE: assert property ($changed(comp_q[0]) && !comp_oe_n_q[0] && $past(!comp_oe_n_q[0])
		|-> $past(run_q[0]) && $past(en_q[0], 2))
		else $error("pair toggled while gated off");
	AST_PD_EDGE: assert property ($rose(pd_park_q) |-> $past(phase_rise) && $past(pd_req))
		else $error("power-down park off the comp falling edge");
	AST_PD_LOOP_OFF: assert property ($rose(pd_park_q) |-> pll_on_q ##1 !pll_on_q)
		else $error("loop not shut after park");
	AST_PD_DRIVE: assert property (pd_park_q && !sleep_park_q |=> true_q == 8'hFF && true_oe_n_q == 8'h00
		&& comp_oe_n_q == 8'hFF)
		else $error("power-down drive park wrong");
	AST_STOP_PARK: assert property (stopped_q[0] && $past(stopped_q[0]) && locked_q && !pd_park_q
		&& !halt_park_q |=> true_q[0] && !true_oe_n_q[0] && comp_oe_n_q[0])
		else $error("stopped pair not parked true high");
	AST_RESUME: assert property ($rose(halt_stable) && stopped_q != 8'h00 |-> ##[1:64] stopped_q == 8'h00)
		else $error("stopped pairs did not resume");

	COV_READ: cover property (tx_done && !tx_acked && state_q == clkbuf_pkg::ST_RDATA);
	COV_WRITE: cover property (rx_valid && state_q == clkbuf_pkg::ST_WDATA);
	COV_PD: cover property ($rose(pd_park_q));
	COV_STOP: cover property ($rose(stopped_q[0]));
endmodule // clock_buffer_smbus_output_control

// file: inc/clkbuf_defs.svh
// Purpose: constants for the clock buffer serial register bank and output gating
// Assumes: 40 MHz block clock
// Notes: register indices are byte indices on the serial bus
`ifndef CLKBUF_DEFS_SVH
`define CLKBUF_DEFS_SVH

`define WR_ADDR 8'hDC
`define RD_ADDR 8'hDD

`define IDX_CTRL 8'h00
`define IDX_EN 8'h01
`define IDX_STOPPABLE 8'h02
`define IDX_RSVD 8'h03
`define IDX_IDENT 8'h04
`define IDX_PART 8'h05
`define IDX_COUNT 8'h06

`define B_SLEEP_PARK 7
`define B_HALT_PARK 6
`define B_SLEEP_SENSE 5
`define B_LOOP_BW 2
`define B_HALVING 0

`define RST_SLEEP_PARK 1'b0
`define RST_HALT_PARK 1'b0
`define RST_SLEEP_SENSE 1'b0
`define RST_LOOP_BW 1'b1
`define RST_HALVING 1'b1
`define RST_EN 8'hFF
`define RST_STOPPABLE 8'h00
`define RST_COUNT 8'h07

`define CLK_PERIOD_NS 25
`define LOCK_TIME_NS 1000000
`define LOCK_CYCLES (`LOCK_TIME_NS / `CLK_PERIOD_NS)

`endif

// file: inc/clkbuf_pkg.sv
// Purpose: types shared by the clock buffer control block
// Assumes: nothing
// Notes: constants live in clkbuf_defs.svh
package clkbuf_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_INDEX = 3'b010,
		ST_WCOUNT = 3'b011,
		ST_WDATA = 3'b100,
		ST_RCOUNT = 3'b101,
		ST_RDATA = 3'b110
	} xfer_state_e;
endpackage

// file: verilog/edge_debounce.sv
// Purpose: synchronise an async pin and accept a level only when stable for two samples
// Assumes: sample_p is a one-cycle pulse on the same clock
// Notes: synced is the plain two-flop copy
module edge_debounce #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin_in,
	input wire logic sample_p,
	output logic synced,
	output logic stable
);
	logic s1_q;
	logic s2_q;
	logic samp_q;
	logic stable_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= RESET_LEVEL;
			s2_q <= RESET_LEVEL;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_q <= RESET_LEVEL;
			stable_q <= RESET_LEVEL;
		end else if (sample_p) begin
			samp_q <= s2_q;
			if (s2_q == samp_q) begin
				stable_q <= s2_q;
			end
		end
	end

	assign synced = s2_q;
	assign stable = stable_q;

	AST_DEBOUNCE_TWO: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(stable_q) |-> $past(sample_p) && $past(s2_q) == $past(samp_q))
		else $error("level accepted without two equal samples");
endmodule // edge_debounce

// file: verilog/smbus_bit_link.sv
// Purpose: serial bus target bit engine: start/stop, byte shift, acknowledge
// Assumes: bus clock far below the block clock
// Notes: byte meaning is decided by the caller through ack_req and tx_mode
module smbus_bit_link (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic start_p,
	output logic stop_p,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	input wire logic ack_req,
	input wire logic tx_mode,
	input wire logic [7:0] tx_byte,
	output logic tx_done,
	output logic tx_acked
);
	logic scl_s1_q, scl_q, scl_p_q, sda_s1_q, sda_q, sda_p_q;
	logic active_q, txing_q, acked_q, drive_low_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic scl_rise, scl_fall;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{scl_s1_q, scl_q, scl_p_q} <= 3'h7;
			{sda_s1_q, sda_q, sda_p_q} <= 3'h7;
		end else begin
			{scl_s1_q, scl_q, scl_p_q} <= {scl_in, scl_s1_q, scl_q};
			{sda_s1_q, sda_q, sda_p_q} <= {sda_in, sda_s1_q, sda_q};
		end
	end

	assign scl_rise = scl_q & ~scl_p_q;
	assign scl_fall = ~scl_q & scl_p_q;
	assign start_p = scl_q & scl_p_q & sda_p_q & ~sda_q;
	assign stop_p = scl_q & scl_p_q & ~sda_p_q & sda_q;
	assign rx_valid = active_q & scl_fall & (cnt_q == 4'h8) & ~txing_q;
	assign tx_done = active_q & scl_rise & (cnt_q == 4'h8) & txing_q;
	assign tx_acked = ~sda_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_q <= 1'b0;
			txing_q <= 1'b0;
			acked_q <= 1'b0;
			drive_low_q <= 1'b0;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
		end else if (start_p) begin
			active_q <= 1'b1;
			txing_q <= 1'b0;
			drive_low_q <= 1'b0;
			cnt_q <= 4'h0;
		end else if (stop_p) begin
			active_q <= 1'b0;
			drive_low_q <= 1'b0;
		end else if (active_q && scl_rise) begin
			if (cnt_q < 4'h8) begin
				if (!txing_q) begin
					shift_q <= {shift_q[6:0], sda_q};
				end
				cnt_q <= cnt_q + 4'h1;
			end else if (cnt_q == 4'h8) begin
				acked_q <= ~sda_q;
				cnt_q <= 4'h9;
			end
		end else if (active_q && scl_fall) begin
			if (cnt_q == 4'h8) begin
				drive_low_q <= ~txing_q & ack_req;
			end else if (cnt_q == 4'h9) begin
				cnt_q <= 4'h0;
				// Unacked byte or host refusal ends our part until the next start
				if (txing_q ? !acked_q : !drive_low_q) begin
					active_q <= 1'b0;
					drive_low_q <= 1'b0;
				end else if (tx_mode) begin
					txing_q <= 1'b1;
					shift_q <= tx_byte;
					drive_low_q <= ~tx_byte[7];
				end else begin
					txing_q <= 1'b0;
					drive_low_q <= 1'b0;
				end
			end else if (cnt_q != 4'h0 && txing_q) begin
				shift_q <= {shift_q[6:0], 1'b0};
				drive_low_q <= ~shift_q[6];
			end
		end
	end

	assign rx_byte = shift_q;
	assign sda_out = 1'b0;
	assign sda_oe_n = ~drive_low_q;
endmodule // smbus_bit_link

// file: dv/smbus_host_model.sv
// Purpose: serial bus host driving the register bank
// Assumes: line resolved with a pull-up in the bench
// Notes: half bit is four block clocks, 200 ns per bit
module smbus_host_model (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_pull
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic hp;
		repeat (4) @(posedge clk);
		#1;
	endtask
	// Extra half bit lets a held ack drop first
	task automatic start;
		sda_pull = 1'b0;
		hp();
		hp();
		scl = 1'b1;
		hp();
		sda_pull = 1'b1;
		hp();
		scl = 1'b0;
	endtask
	task automatic stop;
		sda_pull = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_pull = 1'b0;
		hp();
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_pull = ~b;
		hp();
		scl = 1'b1;
		hp();
		r = sda_line;
		scl = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, ack);
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask
endmodule // smbus_host_model

// file: dv/clock_buffer_smbus_output_control_tb.sv
// Purpose: self-checking bench for the register bank and output gating
// Assumes: lock wait shortened to 20 cycles
// Notes: toggling is judged over a 64 cycle window
module clock_buffer_smbus_output_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] REV = 4'h6; // Arbitrary value
	localparam logic [3:0] MK = 4'h9; // Arbitrary value
	localparam logic [7:0] PC = 8'h3C; // Arbitrary value
	logic clk, arst_n, ref_clock_in, power_down_n, output_halt_n, gate_sense_invert;
	logic scl, sda_pull, sda_out, sda_oe_n, pll_enable, pll_locked, loop_bw, halving;
	logic [7:0] output_gate_pin, clk_out_true, clk_out_comp, true_oe_n, comp_oe_n, c, t;
	logic [63:0] v;
	wire logic sda_line;
	int err_total, n_checks;
	assign sda_line = ~sda_pull & (sda_oe_n | sda_out);
	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	initial begin
		ref_clock_in = 1'b0;
		#37;
		// Reference never stops, so power-down and halt always see comp edges
		forever #100 ref_clock_in = ~ref_clock_in;
	end
	clock_buffer_smbus_output_control #(.LOCK_CYCLES(20), .REVISION_CODE(REV), .MAKER_CODE(MK),
		.PART_CODE(PC)) dut (.clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .ref_clock_in(ref_clock_in), .power_down_n(power_down_n),
		.output_halt_n(output_halt_n), .output_gate_pin(output_gate_pin), .gate_sense_invert(gate_sense_invert),
		.clk_out_true(clk_out_true), .clk_out_comp(clk_out_comp), .true_oe_n(true_oe_n), .comp_oe_n(comp_oe_n),
		.pll_enable(pll_enable), .pll_locked(pll_locked), .loop_bandwidth_select(loop_bw),
		.input_halving_select(halving));
	smbus_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] idx, input int n, input logic [63:0] d);
		logic a, nack;
		host.start();
		host.wbyte(8'hDC, nack);
		host.wbyte(idx, a);
		nack |= a;
		host.wbyte(n[7:0], a);
		nack |= a;
		for (int i = 0; i < n; i++) begin
			host.wbyte(d[8*i+:8], a);
			nack |= a;
		end
		host.stop();
		chk("write acks", 8'h00, {7'h00, nack});
	endtask
	task automatic rd(input logic [7:0] idx, input int n, output logic [7:0] cnt, output logic [63:0] d);
		logic a, nack;
		d = 64'h0;
		host.start();
		host.wbyte(8'hDC, nack);
		host.wbyte(idx, a);
		nack |= a;
		host.start();
		host.wbyte(8'hDD, a);
		nack |= a;
		host.rbyte(1'b0, cnt);
		for (int i = 0; i < n; i++) begin
			host.rbyte(i == n - 1, d[8*i+:8]);
		end
		host.stop();
		chk("read acks", 8'h00, {7'h00, nack});
	endtask
	task automatic toggles(output logic [7:0] tg);
		logic [7:0] p;
		tg = 8'h00;
		p = clk_out_true;
		repeat (64) begin
			cyc(1);
			tg |= clk_out_true ^ p;
			p = clk_out_true;
		end
	endtask
	task automatic wait_pll(input logic en, input logic lk);
		for (int i = 0; i < 2000; i++) begin
			if (pll_enable === en && pll_locked === lk) begin
				return;
			end
			cyc(1);
		end
		err_total++;
		$display("MISMATCH pll wait expected %b%b seen %b%b", en, lk, pll_enable, pll_locked);
		finish_test();
	endtask
	initial begin
		arst_n = 1'b0;
		power_down_n = 1'b1;
		output_halt_n = 1'b1;
		output_gate_pin = 8'hFF;
		gate_sense_invert = 1'b0;
		err_total = 0;
		n_checks = 0;
		cyc(8);
		arst_n = 1'b1;
		wait_pll(1'b1, 1'b1);
		rd(8'h00, 7, c, v);
		chk("count", 8'h07, c);
		chk("reg0", 8'h05, v[7:0]);
		chk("reg1", 8'hFF, v[15:8]);
		chk("reg2", 8'h00, v[23:16]);
		chk("reg3", 8'h00, v[31:24]);
		chk("reg4", {REV, MK}, v[39:32]);
		chk("reg5", PC, v[47:40]);
		chk("reg6", 8'h07, v[55:48]);
		chk("bw", 8'h01, {7'h00, loop_bw});
		$display("Test reset values done");
		host.start();
		host.wbyte(8'hA0, c[0]);
		host.stop();
		chk("foreign nack", 8'h01, {7'h00, c[0]});
		$display("Test foreign address done");
		wr(8'h00, 7, 64'h0003_9900_AA0F_5AE0);
		rd(8'h00, 3, c, v);
		chk("count", 8'h03, c);
		chk("reg0", 8'hE0, v[7:0]);
		chk("reg1", 8'h5A, v[15:8]);
		chk("reg2", 8'h0F, v[23:16]);
		rd(8'h03, 3, c, v);
		chk("reg3", 8'h00, v[7:0]);
		chk("reg4", {REV, MK}, v[15:8]);
		chk("reg5", 8'h99, v[23:16]);
		chk("pins", 8'h00, {6'h00, loop_bw, halving});
		$display("Test block write done");
		cyc(100);
		toggles(t);
		chk("run all", 8'h5A, t);
		output_gate_pin = 8'h0F;
		cyc(100);
		toggles(t);
		chk("run pins", 8'h0A, t);
		gate_sense_invert = 1'b1;
		cyc(100);
		toggles(t);
		chk("run inv", 8'h50, t);
		gate_sense_invert = 1'b0;
		output_gate_pin = 8'hFF;
		$display("Test gating done");
		// Short pulse spans no two comp rises, so must be ignored
		output_halt_n = 1'b0;
		cyc(2);
		output_halt_n = 1'b1;
		toggles(t);
		chk("glitch", 8'h5A, t);
		output_halt_n = 1'b0;
		cyc(150);
		toggles(t);
		chk("halted", 8'h50, t);
		chk("halt oe", 8'hAF, true_oe_n);
		chk("halt comp", 8'h00, clk_out_comp & 8'hAF);
		output_halt_n = 1'b1;
		cyc(156);
		toggles(t);
		chk("resumed", 8'h5A, t);
		$display("Test halt done");
		for (int m = 0; m < 2; m++) begin
			wr(8'h00, 2, {48'h0, 8'hFF, m[0], 7'h60});
			power_down_n = 1'b0;
			wait_pll(1'b0, 1'b0);
			cyc(4);
			chk("pd true oe", m[0] ? 8'hFF : 8'h00, true_oe_n);
			chk("pd comp oe", 8'hFF, comp_oe_n);
			if (m == 0) begin
				chk("pd true", 8'hFF, clk_out_true);
			end
			power_down_n = 1'b1;
			cyc(8);
			chk("wake oe", 8'h00, true_oe_n);
			chk("wake true", 8'hFF, clk_out_true);
			wait_pll(1'b1, 1'b1);
		end
		$display("Test power down done");
		wr(8'h00, 1, 64'h20);
		output_halt_n = 1'b0;
		cyc(150);
		toggles(t);
		chk("halt drv", 8'hF0, t);
		chk("halt drv oe", 8'h00, true_oe_n);
		chk("halt drv coe", 8'h0F, comp_oe_n);
		chk("halt drv true", 8'h0F, clk_out_true & 8'h0F);
		chk("halt drv comp", 8'h00, clk_out_comp & 8'h0F);
		output_halt_n = 1'b1;
		cyc(156);
		toggles(t);
		chk("resume drv", 8'hFF, t);
		$display("Test halt drive done");
		finish_test();
	end
endmodule // clock_buffer_smbus_output_control_tb
